//--- rtl/twoc_params.svh
// Offsets, field positions, reset values and limits of the timer block
`ifndef TWOC_PARAMS_SVH
`define TWOC_PARAMS_SVH

// Byte offsets of the word registers
`define TWOC_OFF_CTRL_A   8'h00
`define TWOC_OFF_CTRL_B   8'h04
`define TWOC_OFF_CMP_A    8'h08
`define TWOC_OFF_CMP_B    8'h0C
`define TWOC_OFF_COUNT    8'h10
`define TWOC_OFF_FLAGS    8'h14
`define TWOC_OFF_PIN_DIR  8'h18

// Field positions
`define TWOC_FA_HI        7
`define TWOC_FA_LO        6
`define TWOC_FB_HI        5
`define TWOC_FB_LO        4
`define TWOC_WLOW_HI      1
`define TWOC_WLOW_LO      0
`define TWOC_WHIGH_BIT    3
`define TWOC_FLAG_OVF     1
`define TWOC_FLAG_A       2
`define TWOC_FLAG_B       3
`define TWOC_DIR_A        0
`define TWOC_DIR_B        1

// Writable masks and reset values
`define TWOC_CTRL_A_MASK  8'hF3
`define TWOC_CTRL_A_RST   8'h00
`define TWOC_CMP_RST      8'h00
`define TWOC_COUNT_RST    8'h00

// Count limits
`define TWOC_MAX          8'hFF
`define TWOC_BOTTOM       8'h00

// Field codes
`define TWOC_ACT_OFF      2'h0
`define TWOC_ACT_TOG      2'h1
`define TWOC_ACT_CLR      2'h2
`define TWOC_ACT_SET      2'h3

`endif

//--- rtl/twoc_pkg.sv
// Types shared by the timer waveform control block
package twoc_pkg;

  typedef enum logic [2:0] {
    TWOC_NORMAL,
    TWOC_CTC,
    TWOC_FAST,
    TWOC_PHASE,
    TWOC_RSVD
  } twoc_class_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } twoc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } twoc_wb_rsp_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } twoc_pin_t;

  typedef struct packed {
    logic level;
  } twoc_chan_state_t;

endpackage

//--- rtl/twoc_out_chan.sv
// One compare output channel: waveform action on match and at top
module twoc_out_chan import twoc_pkg::*; #(
  parameter bit PWM_TOGGLE = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Events and configuration
  input  wire twoc_class_t wclass_i,
  input  wire logic        high_bit_i,
  input  wire logic [1:0]  field_i,
  input  wire logic        match_i,
  input  wire logic        top_i,
  input  wire logic        up_i,
  input  wire logic        eq_top_i,
  // Output level
  output logic             level_o
);

  `include "twoc_params.svh"

  twoc_chan_state_t st_ff;
  twoc_chan_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    case (wclass_i)
      TWOC_NORMAL, TWOC_CTC: begin
        if (match_i) begin
          case (field_i)
            `TWOC_ACT_TOG: nxt_st.level = ~st_ff.level;
            `TWOC_ACT_CLR: nxt_st.level = 1'b0;
            `TWOC_ACT_SET: nxt_st.level = 1'b1;
            default:       nxt_st.level = st_ff.level;
          endcase
        end
      end
      TWOC_FAST: begin
        if (field_i == `TWOC_ACT_TOG) begin
          if (PWM_TOGGLE && high_bit_i && match_i) begin
            nxt_st.level = ~st_ff.level;
          end
        end else if (field_i[1]) begin
          // Top action comes last, so a match at top never wins
          if (match_i && !eq_top_i) begin
            nxt_st.level = field_i[0];
          end
          if (top_i) begin
            nxt_st.level = ~field_i[0];
          end
        end
      end
      TWOC_PHASE: begin
        if (field_i == `TWOC_ACT_TOG) begin
          if (PWM_TOGGLE && high_bit_i && match_i) begin
            nxt_st.level = ~st_ff.level;
          end
        end else if (field_i[1]) begin
          if (match_i && !eq_top_i) begin
            nxt_st.level = up_i ? field_i[0] : ~field_i[0];
          end
          if (top_i && eq_top_i) begin
            nxt_st.level = ~field_i[0];
          end
        end
      end
      default: nxt_st = st_ff;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.level;

endmodule

//--- rtl/twoc_top.sv
// Timer waveform mode decode, counter, compare outputs and bus slave
`include "twoc_params.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RL1: Counter advances only on timer tick enable; one clock throughout.
// RL2: Nonzero A field takes pin A; driver enabled only with direction set.
// RL3: Non-PWM A field: 00 off, 01 toggle, 10 clear, 11 set on match.
// RL4: Fast PWM A: 01 toggles only with high bit; 10/11 act at match, TOP.
// RL5: Phase PWM A: 10 clear up-match, set down-match; 11 reverse; 01 toggles only with high bit.
// RL6: PWM with compare equal TOP and field bit1: ignore match, act at TOP.
// RL7: Nonzero B field takes pin B; driver enabled only with direction set.
// RL8: Non-PWM B field: 00 off, 01 toggle, 10 clear, 11 set on match.
// RL9: Fast PWM B: 01 reserved; 10 clear match set TOP; 11 reverse.
// RL10: Phase PWM B: 10 clears up-match, sets down-match; 11 reverse; 01 none.
// RL11: Control bits 3 and 2 read zero and ignore writes.
// RL12: Two low mode bits plus high bit select sequence, TOP and waveform.
// RL13: Modes: 0 normal,1/5 phase,2 CTC,3/7 fast; TOP FF or compare A.
// RL14: Compare writes immediate in non-PWM, buffered until TOP in PWM.
// RL15: Overflow at MAX in 0,2,3; at BOTTOM in phase; at TOP in 7.
module twoc_top import twoc_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Timer tick
  input  wire logic         tick_i,
  // Wishbone slave
  input  wire twoc_wb_req_t wb_req_i,
  output twoc_wb_rsp_t      wb_rsp_o,
  // Compare pins
  output twoc_pin_t         compare_pin_a_o,
  output twoc_pin_t         compare_pin_b_o
);

  if (ADDR_W != 8) begin : g_chk
    $error("twoc_top: ADDR_W must be 8");
  end

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic       high_bit;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_b;
    logic [7:0] count;
    logic       up;
    logic       block;
    logic [3:0] flags;
    logic [1:0] dir;
    logic       oe_a_n;
    logic       oe_b_n;
    logic       ack;
    logic [7:0] rdat;
  } twoc_state_t;

  localparam twoc_state_t ST_RST = '{
    ctrl_a:    `TWOC_CTRL_A_RST,
    cmp_a_buf: `TWOC_CMP_RST,
    cmp_a:     `TWOC_CMP_RST,
    cmp_b_buf: `TWOC_CMP_RST,
    cmp_b:     `TWOC_CMP_RST,
    count:     `TWOC_COUNT_RST,
    up:        1'b1,
    oe_a_n:    1'b1,
    oe_b_n:    1'b1,
    default:   '0
  };

  twoc_state_t st_ff;
  twoc_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic [2:0]  wave_select_code;
  logic [1:0]  out_a_action_field;
  logic [1:0]  out_b_action_field;
  twoc_class_t wclass;
  logic        top_is_cmp;
  logic [7:0]  top_val;
  logic        pwm;

  assign out_a_action_field = st_ff.ctrl_a[`TWOC_FA_HI:`TWOC_FA_LO];
  assign out_b_action_field = st_ff.ctrl_a[`TWOC_FB_HI:`TWOC_FB_LO];
  assign wave_select_code   = {st_ff.high_bit,
                               st_ff.ctrl_a[`TWOC_WLOW_HI:`TWOC_WLOW_LO]};

  always_comb begin
    wclass     = TWOC_RSVD;
    top_is_cmp = 1'b0;
    case (wave_select_code) // RL12
      3'h0: wclass = TWOC_NORMAL; // RL13
      3'h1: wclass = TWOC_PHASE; // RL13
      3'h2: begin
        wclass     = TWOC_CTC; // RL13
        top_is_cmp = 1'b1;
      end
      3'h3: wclass = TWOC_FAST; // RL13
      3'h5: begin
        wclass     = TWOC_PHASE; // RL13
        top_is_cmp = 1'b1;
      end
      3'h7: begin
        wclass     = TWOC_FAST; // RL13
        top_is_cmp = 1'b1;
      end
      default: wclass = TWOC_RSVD;
    endcase
  end

  assign top_val = top_is_cmp ? st_ff.cmp_a : `TWOC_MAX; // RL13
  assign pwm     = (wclass == TWOC_FAST) || (wclass == TWOC_PHASE);

  ////////////////////////////////////////////////////////////////////////////
  // Timer events
  logic top_ev;
  logic match_a;
  logic match_b;
  logic ovf_ev;

  // A counter write blocks the match of the next tick
  assign top_ev  = tick_i && (st_ff.count == top_val); // RL1
  assign match_a = tick_i && !st_ff.block && (st_ff.count == st_ff.cmp_a);
  assign match_b = tick_i && !st_ff.block && (st_ff.count == st_ff.cmp_b);

  always_comb begin
    case (wave_select_code)
      3'h1, 3'h5: ovf_ev = tick_i && (st_ff.count == `TWOC_BOTTOM) &&
                           !st_ff.up; // RL15
      3'h7:       ovf_ev = top_ev; // RL15
      3'h0, 3'h2, 3'h3: ovf_ev = tick_i &&
                                 (st_ff.count == `TWOC_MAX); // RL15
      default:    ovf_ev = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic       req;
  logic       wr;
  logic [7:0] wdat;
  logic       wr_ctrl_a;
  logic       wr_ctrl_b;
  logic       wr_cmp_a;
  logic       wr_cmp_b;
  logic       wr_count;
  logic       wr_flags;
  logic       wr_dir;
  logic [7:0] rd_mux;

  assign req  = wb_req_i.cyc && wb_req_i.stb && !st_ff.ack;
  assign wr   = req && wb_req_i.we && wb_req_i.sel[0];
  assign wdat = wb_req_i.dat[7:0];

  assign wr_ctrl_a = wr && (wb_req_i.adr == `TWOC_OFF_CTRL_A);
  assign wr_ctrl_b = wr && (wb_req_i.adr == `TWOC_OFF_CTRL_B);
  assign wr_cmp_a  = wr && (wb_req_i.adr == `TWOC_OFF_CMP_A);
  assign wr_cmp_b  = wr && (wb_req_i.adr == `TWOC_OFF_CMP_B);
  assign wr_count  = wr && (wb_req_i.adr == `TWOC_OFF_COUNT);
  assign wr_flags  = wr && (wb_req_i.adr == `TWOC_OFF_FLAGS);
  assign wr_dir    = wr && (wb_req_i.adr == `TWOC_OFF_PIN_DIR);

  always_comb begin
    rd_mux = 8'h00;
    case (wb_req_i.adr)
      `TWOC_OFF_CTRL_A:  rd_mux = st_ff.ctrl_a & `TWOC_CTRL_A_MASK; // RL11
      `TWOC_OFF_CTRL_B:  rd_mux[`TWOC_WHIGH_BIT] = st_ff.high_bit;
      `TWOC_OFF_CMP_A:   rd_mux = st_ff.cmp_a_buf;
      `TWOC_OFF_CMP_B:   rd_mux = st_ff.cmp_b_buf;
      `TWOC_OFF_COUNT:   rd_mux = st_ff.count;
      `TWOC_OFF_FLAGS:   rd_mux = {4'h0, st_ff.flags};
      `TWOC_OFF_PIN_DIR: rd_mux = {6'h00, st_ff.dir};
      default:           rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.ack  = req;
    nxt_st.rdat = req ? rd_mux : 8'h00;

    if (wr_ctrl_a) begin
      nxt_st.ctrl_a = wdat & `TWOC_CTRL_A_MASK; // RL11
    end
    if (wr_ctrl_b) begin
      nxt_st.high_bit = wdat[`TWOC_WHIGH_BIT];
    end
    if (wr_dir) begin
      nxt_st.dir = wdat[1:0];
    end
    if (wr_cmp_a) begin
      nxt_st.cmp_a_buf = wdat;
    end
    if (wr_cmp_b) begin
      nxt_st.cmp_b_buf = wdat;
    end

    // Active compare values follow the buffer at once outside PWM
    if (!pwm) begin
      nxt_st.cmp_a = wr_cmp_a ? wdat : st_ff.cmp_a_buf; // RL14
      nxt_st.cmp_b = wr_cmp_b ? wdat : st_ff.cmp_b_buf; // RL14
    end else if (top_ev) begin
      nxt_st.cmp_a = st_ff.cmp_a_buf; // RL14
      nxt_st.cmp_b = st_ff.cmp_b_buf; // RL14
    end

    // Counter
    if (tick_i) begin
      nxt_st.block = 1'b0;
      case (wclass)
        TWOC_NORMAL: nxt_st.count = 8'(st_ff.count + 8'h01); // RL1
        TWOC_CTC, TWOC_FAST: begin
          nxt_st.count = top_ev ? `TWOC_BOTTOM :
                         8'(st_ff.count + 8'h01); // RL1
        end
        TWOC_PHASE: begin
          if (st_ff.up && top_ev) begin
            nxt_st.up    = 1'b0;
            nxt_st.count = 8'(st_ff.count - 8'h01);
          end else if (!st_ff.up && st_ff.count == `TWOC_BOTTOM) begin
            nxt_st.up    = 1'b1;
            nxt_st.count = 8'(st_ff.count + 8'h01);
          end else if (st_ff.up) begin
            nxt_st.count = 8'(st_ff.count + 8'h01);
          end else begin
            nxt_st.count = 8'(st_ff.count - 8'h01);
          end
        end
        default: nxt_st.count = st_ff.count;
      endcase
    end
    if (wclass != TWOC_PHASE) begin
      nxt_st.up = 1'b1;
    end
    if (wr_count) begin
      nxt_st.count = wdat;
      nxt_st.block = 1'b1;
    end

    // Sticky flags: a new event wins over a write-one clear
    nxt_st.flags = st_ff.flags & ~(wr_flags ? wdat[3:0] : 4'h0);
    if (ovf_ev) begin
      nxt_st.flags[`TWOC_FLAG_OVF] = 1'b1; // RL15
    end
    if (match_a) begin
      nxt_st.flags[`TWOC_FLAG_A] = 1'b1;
    end
    if (match_b) begin
      nxt_st.flags[`TWOC_FLAG_B] = 1'b1;
    end
    nxt_st.flags[0] = 1'b0;

    // Pin override and driver enable
    nxt_st.oe_a_n = !((out_a_action_field != `TWOC_ACT_OFF) &&
                      st_ff.dir[`TWOC_DIR_A]); // RL2
    nxt_st.oe_b_n = !((out_b_action_field != `TWOC_ACT_OFF) &&
                      st_ff.dir[`TWOC_DIR_B]); // RL7
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output channels
  logic level_a;
  logic level_b;

  // Channel A allows the toggle in PWM; channel B does not
  twoc_out_chan #(.PWM_TOGGLE(1'b1)) u_chan_a ( // RL3 RL4 RL5 RL6
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wclass_i   (wclass),
    .high_bit_i (st_ff.high_bit),
    .field_i    (out_a_action_field),
    .match_i    (match_a),
    .top_i      (top_ev),
    .up_i       (st_ff.up),
    .eq_top_i   (st_ff.cmp_a == top_val),
    .level_o    (level_a)
  );

  twoc_out_chan #(.PWM_TOGGLE(1'b0)) u_chan_b ( // RL8 RL9 RL10 RL6
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wclass_i   (wclass),
    .high_bit_i (st_ff.high_bit),
    .field_i    (out_b_action_field),
    .match_i    (match_b),
    .top_i      (top_ev),
    .up_i       (st_ff.up),
    .eq_top_i   (st_ff.cmp_b == top_val),
    .level_o    (level_b)
  );

  assign compare_pin_a_o = '{level: level_a, oe_n: st_ff.oe_a_n};
  assign compare_pin_b_o = '{level: level_b, oe_n: st_ff.oe_b_n};
  assign wb_rsp_o        = '{ack: st_ff.ack, dat: {24'h000000, st_ff.rdat}};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_req_i.cyc && wb_req_i.stb && !st_ff.ack;
  endsequence

  sequence s_ack_pulse;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence

  sequence s_fast_top_a;
    wclass == TWOC_FAST && out_a_action_field == `TWOC_ACT_CLR && top_ev;
  endsequence

  AST_ACK_PULSE: assert property (s_req |=> s_ack_pulse)
    else $error("ack not a single cycle after request");
  AST_RSVD_ZERO: assert property ( // RL11
    st_ff.ctrl_a[3:2] == 2'b00)
    else $error("reserved control bits hold a one");
  AST_OE_A: assert property ( // RL2
    (out_a_action_field != 2'h0 && st_ff.dir[0]) |=> !compare_pin_a_o.oe_n)
    else $error("pin A driver not enabled");
  AST_OE_B: assert property ( // RL7
    (out_b_action_field == 2'h0 || !st_ff.dir[1]) |=> compare_pin_b_o.oe_n)
    else $error("pin B driven while disconnected");
  AST_NP_TOGGLE: assert property ( // RL3
    (wclass == TWOC_NORMAL && out_a_action_field == 2'h1 && match_a)
    |=> compare_pin_a_o.level != $past(compare_pin_a_o.level))
    else $error("pin A did not toggle on match");
  AST_FAST_TOP: assert property (s_fast_top_a |=> compare_pin_a_o.level) // RL4
    else $error("pin A not set at top");
  AST_PH_UP_CLR: assert property ( // RL5
    (wclass == TWOC_PHASE && out_a_action_field == 2'h2 && match_a &&
     st_ff.up && st_ff.cmp_a != top_val) |=> !compare_pin_a_o.level)
    else $error("pin A not cleared on up match");
  AST_EQ_TOP_B: assert property ( // RL6
    (wclass == TWOC_FAST && out_b_action_field[1] && top_ev &&
     st_ff.cmp_b == top_val)
    |=> compare_pin_b_o.level == !$past(out_b_action_field[0]))
    else $error("pin B top action lost at equal top");
  AST_B_RSVD: assert property ( // RL9
    (pwm && out_b_action_field == 2'h1) |=> $stable(compare_pin_b_o.level))
    else $error("pin B moved in reserved setting");
  AST_HOLD: assert property ( // RL1
    (!tick_i && !wr_count) |=> $stable(st_ff.count))
    else $error("counter moved without tick");
  AST_BUF: assert property ( // RL14
    (pwm && !top_ev) |=> $stable(st_ff.cmp_a) && $stable(st_ff.cmp_b))
    else $error("compare value changed before top");
  AST_CTC_WRAP: assert property ( // RL13
    (wclass == TWOC_CTC && top_ev && !wr_count) |=> st_ff.count == 8'h00)
    else $error("counter not cleared at compare top");
  AST_OVF_PH: assert property ( // RL15
    (wclass == TWOC_PHASE && tick_i && st_ff.count == 8'h00 && !st_ff.up)
    |=> st_ff.flags[1] ##1 1'b1)
    else $error("overflow not set at bottom");

endmodule

//--- dv/twoc_top_test.sv
// Self-checking bench for the timer waveform control block
`include "twoc_params.svh"

module twoc_top_test import twoc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] CA = `TWOC_OFF_CTRL_A;
  localparam logic [7:0] CB = `TWOC_OFF_CTRL_B;
  localparam logic [7:0] PA = `TWOC_OFF_CMP_A;
  localparam logic [7:0] PB = `TWOC_OFF_CMP_B;
  localparam logic [7:0] CN = `TWOC_OFF_COUNT;
  localparam logic [7:0] FL = `TWOC_OFF_FLAGS;
  localparam logic [7:0] DR = `TWOC_OFF_PIN_DIR;

  logic         clk_i;
  logic         rst_i;
  logic         tick_i;
  twoc_wb_req_t wb_req;
  twoc_wb_rsp_t wb_rsp;
  twoc_pin_t    pin_a;
  twoc_pin_t    pin_b;
  int           num_errors;
  int           checks_done;

  twoc_top u_twoc_top (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .tick_i          (tick_i),
    .wb_req_i        (wb_req),
    .wb_rsp_o        (wb_rsp),
    .compare_pin_a_o (pin_a),
    .compare_pin_b_o (pin_b)
  );

  always #2 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Called just after a rising edge; holds the cycle until ack is sampled
  // A lost answer is left to the watchdog, so it cannot pass unseen
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1,
               dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    check(nm, q, exp);
  endtask

  task automatic mode(input logic [2:0] m, input logic [1:0] fa,
                      input logic [1:0] fb);
    wr(CA, {fa, fb, 2'h0, m[1:0]});
    wr(CB, {4'h0, m[2], 3'h0});
  endtask

  // Pulses on the tick enable; results are settled on return
  task automatic ticks(input int n);
    repeat (n) begin
      tick_i <= 1'b1;
      @(posedge clk_i);
    end
    tick_i <= 1'b0;
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rc("ctrl_a reset", CA, 8'h00);
    rc("count reset", CN, 8'h00);
    wr(CA, 8'hFF);
    rc("ctrl_a reserved", CA, 8'hF3);
    rc("unmapped read", 8'h1C, 8'h00);
    wr(CA, 8'h00);
  endtask

  task automatic t_pins();
    wr(DR, 8'h00);
    mode(3'h0, `TWOC_ACT_SET, `TWOC_ACT_TOG);
    check("oe_n a no dir", {7'h0, pin_a.oe_n}, 8'h01);
    check("oe_n b no dir", {7'h0, pin_b.oe_n}, 8'h01);
    wr(DR, 8'h03);
    check("oe_n a driven", {7'h0, pin_a.oe_n}, 8'h00);
    check("oe_n b driven", {7'h0, pin_b.oe_n}, 8'h00);
    mode(3'h0, `TWOC_ACT_OFF, `TWOC_ACT_OFF);
    check("oe_n a off", {7'h0, pin_a.oe_n}, 8'h01);
    check("oe_n b off", {7'h0, pin_b.oe_n}, 8'h01);
  endtask

  // Normal and CTC: set, clear, toggle twice on a match at 5
  task automatic t_nonpwm();
    logic [1:0] seq [4] = '{`TWOC_ACT_SET, `TWOC_ACT_CLR,
                            `TWOC_ACT_TOG, `TWOC_ACT_TOG};
    logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(PA, 8'h05);
    wr(PB, 8'h05);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        mode(3'(2 * m), seq[i], seq[i]);
        wr(CN, 8'h04);
        ticks(2);
        check("level a", {7'h0, pin_a.level}, {7'h0, exp[i]});
        check("level b", {7'h0, pin_b.level}, {7'h0, exp[i]});
      end
    end
  endtask

  // Count sequence and overflow per mode except phase modes 1 and 5; compare A is 5
  task automatic t_modes();
    logic [2:0] md [7] = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h3, 3'h4, 3'h6};
    logic [7:0] st [7] = '{8'hFE, 8'h04, 8'h04, 8'h04, 8'hFE, 8'h09, 8'h09};
    logic [7:0] en [7] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h09, 8'h09};
    logic       ov [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0] q;
    for (int i = 0; i < 7; i++) begin
      mode(md[i], `TWOC_ACT_OFF, `TWOC_ACT_OFF);
      wr(FL, 8'h0E);
      wr(CN, st[i]);
      ticks(2);
      rc("count", CN, en[i]);
      wb(1'b0, FL, 8'h00, q);
      check("overflow", {7'h0, q[`TWOC_FLAG_OVF]}, {7'h0, ov[i]});
    end
  endtask

  task automatic t_fast();
    mode(3'h3, `TWOC_ACT_SET, `TWOC_ACT_OFF);
    wr(PA, 8'h20);
    wr(CN, 8'h04);
    ticks(2);
    check("fast old cmp", {7'h0, pin_a.level}, 8'h01);
    wr(CN, 8'hFE);
    ticks(2);
    check("fast top", {7'h0, pin_a.level}, 8'h00);
    wr(CN, 8'h04);
    ticks(2);
    check("fast stale", {7'h0, pin_a.level}, 8'h00);
    wr(CN, 8'h1F);
    ticks(2);
    check("fast new cmp", {7'h0, pin_a.level}, 8'h01);
    mode(3'h7, `TWOC_ACT_TOG, `TWOC_ACT_TOG);
    wr(CN, 8'h04);
    ticks(2);
    check("fast b rsvd", {7'h0, pin_b.level}, 8'h00);
    wr(CN, 8'h1F);
    ticks(2);
    check("fast a toggle", {7'h0, pin_a.level}, 8'h00);
  endtask

  // Direction is still up here: phase mode not yet entered
  task automatic t_phase();
    logic [7:0] q;
    mode(3'h0, `TWOC_ACT_OFF, `TWOC_ACT_OFF);
    wr(PB, 8'hFF);
    mode(3'h1, `TWOC_ACT_CLR, `TWOC_ACT_CLR);
    wr(CN, 8'hFE);
    ticks(2);
    check("cmp at top b", {7'h0, pin_b.level}, 8'h01);
    wr(CN, 8'h21);
    ticks(2);
    check("down match a", {7'h0, pin_a.level}, 8'h01);
    wr(FL, 8'h0E);
    wr(CN, 8'h01);
    ticks(1);
    wb(1'b0, FL, 8'h00, q);
    check("ovf early", {7'h0, q[`TWOC_FLAG_OVF]}, 8'h00);
    ticks(1);
    wb(1'b0, FL, 8'h00, q);
    check("ovf bottom", {7'h0, q[`TWOC_FLAG_OVF]}, 8'h01);
    wr(CN, 8'h1F);
    ticks(2);
    check("up match a", {7'h0, pin_a.level}, 8'h00);
    // Fast PWM with compare B at top: match ignored, clear at top wins
    mode(3'h3, `TWOC_ACT_CLR, `TWOC_ACT_SET);
    wr(CN, 8'hFE);
    ticks(2);
    check("fast top a clr", {7'h0, pin_a.level}, 8'h01);
    check("fast eq top b", {7'h0, pin_b.level}, 8'h00);
    // Phase PWM turning at compare A instead of 0xFF
    mode(3'h5, `TWOC_ACT_OFF, `TWOC_ACT_OFF);
    wr(CN, 8'h1F);
    ticks(3);
    rc("phase cmp top", CN, 8'h1E);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs a few hundred cycles; this limit is far beyond that
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end

  initial begin
    clk_i       = 1'b0;
    rst_i       = 1'b1;
    tick_i      = 1'b0;
    wb_req      = '0;
    num_errors  = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_pins();
    t_nonpwm();
    t_modes();
    t_fast();
    t_phase();
    wrap_up();
  end
endmodule
